//--- hw/qsd_core.sv
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Function
// [RULE1] while running, sample phases a and b once per programmed sample period
// [RULE2] sample continuously after start, comparing each pair with the previous pair
// [RULE3] unchanged pair gives value 0, accumulators untouched
// [RULE4] forward gray step gives value 1 and increments motion accumulator
// [RULE5] reverse gray step gives value -1 and decrements motion accumulator
// [RULE6] both phases changed gives value 2 and increments double-transition counter
// [RULE7] software stops and waits for stopped event before changing sample period
// [RULE8] other settings preferably changed only while stopped
// [RULE9] raise sample-ready event for every new sample value written
// [RULE10] step overflowing the motion accumulator is dropped and raises overflow event
// [RULE11] start captures the initial pair as previous, so first sample is quiet
module qsd_core
    import qsd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    output logic             irq
);
    // ==========================================================
    // state
    // ==========================================================
    logic                 aw_held_q;
    logic [7:0]           aw_addr_q;
    logic                 w_held_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 running_q;
    logic [QSD_PER_W-1:0] period_q;
    logic [QSD_PER_W-1:0] tick_cnt_q;
    logic [1:0]           prev_ab_q;
    logic [1:0]           sample_q;
    logic [QSD_ACC_W-1:0] acc_q;
    logic [QSD_DBL_W-1:0] dbl_q;
    logic [QSD_EV_W-1:0]  events_q;
    logic [QSD_EV_W-1:0]  inten_q;
    qsd_step_t            step;
    logic                 wr_fire;
    logic                 start_w;
    logic                 stop_w;
    logic                 tick;
    logic                 clr_acc_w;
    logic                 clr_dbl_w;
    logic                 acc_of;
    logic [QSD_EV_W-1:0]  ev_set;
    logic [QSD_EV_W-1:0]  ev_clr;

    // helper: a register write that hits a given offset
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
        return (a[7:2] == off[7:2]);
    endfunction

    // ==========================================================
    // axi4-lite write channel
    // ==========================================================
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    // address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= QSD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > QSD_OFF_INTEN) ? QSD_RESP_SLVERR : QSD_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // write strobes for tasks; only byte lane 0 carries them
    assign start_w   = wr_fire && w_strb_q[0] && wr_hit(aw_addr_q, QSD_OFF_CTRL) && w_data_q[QSD_BIT_START];
    assign stop_w    = wr_fire && w_strb_q[0] && wr_hit(aw_addr_q, QSD_OFF_CTRL) && w_data_q[QSD_BIT_STOP];
    assign clr_acc_w = wr_fire && w_strb_q[0] && wr_hit(aw_addr_q, QSD_OFF_CLRACC) && w_data_q[0];
    assign clr_dbl_w = wr_fire && w_strb_q[0] && wr_hit(aw_addr_q, QSD_OFF_CLRACC) && w_data_q[1];
    assign ev_clr    = (wr_fire && w_strb_q[0] && wr_hit(aw_addr_q, QSD_OFF_EVCLR))
                       ? w_data_q[QSD_EV_W-1:0] : '0;

    // ==========================================================
    // settings
    // ==========================================================
    // period written any time; changing it while running is software's problem
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_q <= QSD_PER_RST;
        end else if (wr_fire && wr_hit(aw_addr_q, QSD_OFF_PERIOD)) begin
            if (w_strb_q[0]) period_q[7:0]  <= w_data_q[7:0];
            if (w_strb_q[1]) period_q[15:8] <= w_data_q[15:8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inten_q <= '0;
        end else if (wr_fire && w_strb_q[0] && wr_hit(aw_addr_q, QSD_OFF_INTEN)) begin
            inten_q <= w_data_q[QSD_EV_W-1:0];
        end
    end

    // ==========================================================
    // run control and sample timing
    // ==========================================================
    // stop wins over a start in the same write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running_q <= 1'b0;
        end else if (stop_w) begin
            running_q <= 1'b0;
        end else if (start_w) begin
            running_q <= 1'b1;                             // [RULE2]
        end
    end

    // one sample every period_q+1 cycles
    assign tick = running_q && (tick_cnt_q == period_q);   // [RULE1]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= '0;
        end else if (!running_q || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // ==========================================================
    // decode and accumulate
    // ==========================================================
    qsd_decode u_decode (
        .prev_ab (prev_ab_q),
        .curr_ab ({phase_a, phase_b}),
        .step    (step)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ab_q <= 2'b00;
        end else if ((start_w && !running_q) || tick) begin
            prev_ab_q <= {phase_a, phase_b};               // [RULE11] [RULE2]
        end
    end

    // sample register: 0, 1, -1 (2'b11) or 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_q <= 2'b00;
        end else if (tick) begin
            unique case (step)
                QSD_STEP_NONE: sample_q <= 2'b00;          // [RULE3]
                QSD_STEP_POS:  sample_q <= 2'b01;          // [RULE4]
                QSD_STEP_NEG:  sample_q <= 2'b11;          // [RULE5]
                QSD_STEP_DBL:  sample_q <= 2'b10;          // [RULE6]
            endcase
        end
    end

    // signed saturation check instead of wrapping
    assign acc_of = tick && ((step == QSD_STEP_POS && acc_q == {1'b0, {(QSD_ACC_W-1){1'b1}}})
                          || (step == QSD_STEP_NEG && acc_q == {1'b1, {(QSD_ACC_W-1){1'b0}}}));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= '0;
        end else if (clr_acc_w) begin
            acc_q <= '0;
        end else if (tick && !acc_of) begin
            if (step == QSD_STEP_POS) acc_q <= acc_q + 1'b1;   // [RULE4] [RULE10]
            if (step == QSD_STEP_NEG) acc_q <= acc_q - 1'b1;   // [RULE5] [RULE10]
        end
    end

    // double counter sticks at its top rather than wrapping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbl_q <= '0;
        end else if (clr_dbl_w) begin
            dbl_q <= '0;
        end else if (tick && step == QSD_STEP_DBL && dbl_q != '1) begin
            dbl_q <= dbl_q + 1'b1;                         // [RULE6]
        end
    end

    // ==========================================================
    // events and interrupt
    // ==========================================================
    assign ev_set[QSD_EV_SAMPLE]  = tick;                  // [RULE9]
    assign ev_set[QSD_EV_ACCUMULATOR_OVERFLOW_EVENT]   = acc_of;                // [RULE10]
    assign ev_set[QSD_EV_STOPPED] = stop_w;

    // set beats a clear landing in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            events_q <= '0;
        end else begin
            events_q <= (events_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((events_q & ~ev_clr) | ev_set) & inten_q);
        end
    end

    // ==========================================================
    // axi4-lite read channel
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= QSD_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= QSD_RESP_OKAY;
                unique case ({s_axi_araddr[7:2], 2'b00})
                    QSD_OFF_STATUS: s_axi_rdata <= {31'h0, running_q};
                    QSD_OFF_PERIOD: s_axi_rdata <= {16'h0, period_q};
                    QSD_OFF_SAMPLE: s_axi_rdata <= {{30{sample_q[1] & sample_q[0]}}, sample_q};
                    QSD_OFF_ACC:    s_axi_rdata <= acc_q;
                    QSD_OFF_DBL:    s_axi_rdata <= {28'h0, dbl_q};
                    QSD_OFF_EVENTS: s_axi_rdata <= {29'h0, events_q};
                    QSD_OFF_INTEN:  s_axi_rdata <= {29'h0, inten_q};
                    QSD_OFF_CTRL, QSD_OFF_CLRACC, QSD_OFF_EVCLR: s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= QSD_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- inc/qsd_pkg.sv
package qsd_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] QSD_OFF_CTRL    = 8'h00;  // w: bit0 start task, bit1 stop task
    localparam logic [7:0] QSD_OFF_STATUS  = 8'h04;  // r: bit0 running
    localparam logic [7:0] QSD_OFF_PERIOD  = 8'h08;  // rw: sample_period_setting
    localparam logic [7:0] QSD_OFF_SAMPLE  = 8'h0c;  // r: signed sample value
    localparam logic [7:0] QSD_OFF_ACC     = 8'h10;  // r: motion_accumulator
    localparam logic [7:0] QSD_OFF_DBL     = 8'h14;  // r: double_transition_counter
    localparam logic [7:0] QSD_OFF_CLRACC  = 8'h18;  // w: bit0 clear acc, bit1 clear dbl
    localparam logic [7:0] QSD_OFF_EVENTS  = 8'h20;  // r: sticky events
    localparam logic [7:0] QSD_OFF_EVCLR   = 8'h24;  // w: write 1 to clear event
    localparam logic [7:0] QSD_OFF_INTEN   = 8'h28;  // rw: interrupt enable

    // ==========================================================
    // fields and reset values
    // ==========================================================
    localparam int QSD_BIT_START   = 0;
    localparam int QSD_BIT_STOP    = 1;
    localparam int QSD_EV_SAMPLE   = 0;  // sample_ready_event
    localparam int QSD_EV_ACCUMULATOR_OVERFLOW_EVENT    = 1;  // accumulator_overflow_event
    localparam int QSD_EV_STOPPED  = 2;
    localparam int QSD_EV_W        = 3;
    localparam int QSD_PER_W       = 16;
    localparam int QSD_ACC_W       = 32;
    localparam int QSD_DBL_W       = 4;
    localparam logic [QSD_PER_W-1:0] QSD_PER_RST = 16'h007c;  // 125 cycles = 1 us
    localparam logic [1:0] QSD_RESP_OKAY   = 2'b00;
    localparam logic [1:0] QSD_RESP_SLVERR = 2'b10;

    // decoded step classes
    typedef enum logic [1:0] {
        QSD_STEP_NONE,
        QSD_STEP_POS,
        QSD_STEP_NEG,
        QSD_STEP_DBL
    } qsd_step_t;

endpackage

//--- hw/qsd_decode.sv
`timescale 1ns/1ps
// classes one phase pair against the previous one
module qsd_decode
    import qsd_pkg::*;
(
    input  wire logic [1:0] prev_ab,
    input  wire logic [1:0] curr_ab,
    output qsd_step_t       step
);
    // ==========================================================
    // gray-code step table, ab = {a, b}
    // ==========================================================
    always_comb begin
        step = QSD_STEP_NONE;                          // [RULE3]
        if (prev_ab != curr_ab) begin
            if ((prev_ab ^ curr_ab) == 2'b11) begin
                step = QSD_STEP_DBL;                   // [RULE6]
            end else begin
                unique case ({prev_ab, curr_ab})
                    4'b0001, 4'b0111, 4'b1110, 4'b1000: step = QSD_STEP_POS;  // [RULE4]
                    default:                            step = QSD_STEP_NEG;  // [RULE5]
                endcase
            end
        end
    end
endmodule

//--- bench/qsd_encoder_model.sv
`timescale 1ns/1ps
// ==========================================================
// encoder model
// ==========================================================
module qsd_encoder_model
(
    input  wire logic       aclk,
    input  wire logic [1:0] ab_cmd,
    output logic            phase_a,
    output logic            phase_b
);
    // phases change only at the clock, so a pair never lands half-updated
    always_ff @(posedge aclk) begin
        phase_a <= ab_cmd[1];
        phase_b <= ab_cmd[0];
    end
endmodule

//--- bench/qsd_core_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// bus and interrupt checker
// ==========================================================
module qsd_core_asserts
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // handshake steps of a read and of a joint write
    sequence ar_hs;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence w_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    r_answer_a: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    b_answer_a: assert property (w_both |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    r_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    // reset itself is the antecedent here, so no disable
    rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active in reset");
endmodule

bind qsd_core qsd_core_asserts u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);

//--- bench/tb_quadrature_sample_decoder.sv
`timescale 1ns/1ps
module tb_quadrature_sample_decoder
    import qsd_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, pa, pb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v, acc_e, dbl_e;
    logic [1:0]  bresp, rresp, ab, prev;
    logic [3:0]  wstrb;
    int          errors, check_count;
    // every prev/current pair at least once, 0 to 0 twice
    logic [1:0]  seq [17] = '{0, 0, 1, 0, 2, 0, 3, 1, 1, 2, 1, 3, 2, 2, 3, 3, 0};

    // ==========================================================
    // clock, design and encoder
    // ==========================================================
    always #4 aclk = ~aclk;
    qsd_core DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .phase_a(pa),
        .phase_b(pb), .irq(irq)
    );
    qsd_encoder_model u_enc (.aclk(aclk), .ab_cmd(ab), .phase_a(pa), .phase_b(pb));

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = QSD_RESP_OKAY);
        logic aw, w;
        aw = 1;
        w = 1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 0;
                awvalid <= 0;
            end
            if (w && wready === 1'b1) begin
                w = 0;
                wvalid <= 0;
            end
        end
        // response left waiting a cycle so its hold check sees a stall
        repeat (2) @(posedge aclk);
        bready <= 1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er = QSD_RESP_OKAY);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        // read answer left waiting one edge so its hold check sees a stall
        @(posedge aclk);
        rready <= 1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
        v = rdata;
        chk(rresp, er);
    endtask
    // bounded poll; returning just after a tick leaves a whole period
    task automatic wait_sample;
        wr(QSD_OFF_EVCLR, 32'h1);
        v = 0;
        for (int i = 0; i < 400 && v[0] !== 1'b1; i++) rd(QSD_OFF_EVENTS);
        chk(v[0], 1);
    endtask
    // gray position: 00,01,11,10 in order
    function automatic logic [31:0] exp_s(input logic [1:0] p, input logic [1:0] c);
        logic [1:0] d;
        d = {c[1], c[1] ^ c[0]} - {p[1], p[1] ^ p[0]};
        return (d == 2'd3) ? 32'hffffffff : {30'h0, d};
    endfunction
    task automatic step(input logic [1:0] x);
        logic [31:0] s;
        s = exp_s(prev, x);
        ab <= x;
        wait_sample;
        rd(QSD_OFF_SAMPLE);
        chk(v, s);
        acc_e = acc_e + ((s == 32'h1) ? 1 : 0) - ((s == 32'hffffffff) ? 1 : 0);
        dbl_e = dbl_e + ((s == 32'h2) ? 1 : 0);
        rd(QSD_OFF_ACC);
        chk(v, acc_e);
        rd(QSD_OFF_DBL);
        chk(v, dbl_e);
        prev = x;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // tests
    // ==========================================================
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ab, prev} = '0;
        {awaddr, araddr, wdata, acc_e, dbl_e} = '0;
        wstrb = 4'hf;
        errors = 0;
        check_count = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(QSD_OFF_PERIOD);
        chk(v, 32'h0000007c);
        rd(QSD_OFF_STATUS);
        chk(v, 32'h0);
        rd(8'h2c, QSD_RESP_SLVERR);
        wr(8'h30, 32'h1, QSD_RESP_SLVERR);
        $display("test reset_map done");
        // long period so each poll and read fits between two ticks
        wr(QSD_OFF_PERIOD, 32'd200);
        wr(QSD_OFF_INTEN, 32'h1);
        wr(QSD_OFF_CTRL, 32'h1);
        for (int i = 0; i < 17; i++) step(seq[i]);
        chk(irq, 1);
        $display("test decode done");
        wr(QSD_OFF_CTRL, 32'h2);
        rd(QSD_OFF_EVENTS);
        chk(v[2], 1);
        rd(QSD_OFF_STATUS);
        chk(v, 32'h0);
        wr(QSD_OFF_EVCLR, 32'h7);
        ab <= 2'd1;
        repeat (600) @(posedge aclk);
        rd(QSD_OFF_EVENTS);
        chk(v, 32'h0);
        chk(irq, 0);
        wr(QSD_OFF_PERIOD, 32'd50);
        rd(QSD_OFF_PERIOD);
        chk(v, 32'd50);
        wr(QSD_OFF_CTRL, 32'h1);
        prev = 2'd1;
        step(2'd1);
        step(2'd3);
        $display("test restart done");
        wr(QSD_OFF_INTEN, 32'h0);
        @(posedge aclk);
        chk(irq, 0);
        wr(QSD_OFF_INTEN, 32'h1);
        @(posedge aclk);
        chk(irq, 1);
        wr(QSD_OFF_CLRACC, 32'h3);
        rd(QSD_OFF_ACC);
        chk(v, 32'h0);
        rd(QSD_OFF_DBL);
        chk(v, 32'h0);
        $display("test irq_clear done");
        wrap_up;
    end
    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        wrap_up;
    end
endmodule
